// ===== pkg/tx_pulse_consts.vh
// Constants for the transmit pulse template access block
`ifndef TX_PULSE_CONSTS_VH
`define TX_PULSE_CONSTS_VH

// Register indices; byte address is four times the index
`define IDX_CH1_SCALE 6'h06
`define IDX_CH1_CMD 6'h07
`define IDX_CH1_DATA 6'h08
`define IDX_CH2_SCALE 6'h26
`define IDX_CH2_CMD 6'h27
`define IDX_CH2_DATA 6'h28

// Reset values
`define RST_SCALE 6'h21
`define RST_CMD 8'h00
`define RST_DATA 7'h00
`define RST_TEMPLATE 4'h0

// Command register fields
`define CMD_GO_BIT 7
`define CMD_DIR_BIT 6
`define CMD_UI_HI 5
`define CMD_UI_LO 4
`define CMD_SAMP_HI 3
`define CMD_SAMP_LO 0

// Amplitude scale field and template data field
`define SCALE_HI 5
`define DATA_HI 6

// Recommended scale values per line type
`define SCALE_T1_SHORT 6'h36
`define SCALE_DS1_M75 6'h11
`define SCALE_DS1_M150 6'h08
`define SCALE_DS1_M225 6'h04
`define SCALE_E1 6'h21

// Amplitude step per scale unit, in hundredths of a percent
`define STEP_T1_SHORT 12'd200
`define STEP_DS1_M75 12'd625
`define STEP_DS1_M150 12'd1250
`define STEP_DS1_M225 12'd2500
`define STEP_E1 12'd300

// Template select codes
`define SEL_E1_INT 4'h0
`define SEL_E1_EXT 4'h1
`define SEL_DS1_0DB 4'h8
`define SEL_DS1_M75 4'h9
`define SEL_DS1_M150 4'ha
`define SEL_DS1_M225 4'hb
`define SEL_USER_HI 2'h3

// AHB encodings
`define HTRANS_NONSEQ 2'h2
`define HTRANS_SEQ 2'h3

`endif

// ===== verilog/template_channel.v
// One channel: scale, command, data registers and the 64-entry template RAM
`timescale 1ns/10ps
`default_nettype none
`include "tx_pulse_consts.vh"

module template_channel (
   input wire clock,
   input wire rst,
   input wire wr_scale,
   input wire wr_cmd,
   input wire wr_data,
   input wire [7:0] wdata,
   input wire user_mode,
   input wire [5:0] shaper_index,
   output reg [5:0] scale_reg,
   output reg [7:0] cmd_reg,
   output reg [6:0] data_reg,
   output reg [6:0] shaper_sample_reg
);

   reg [6:0] ram [0:63];
   wire go;
   wire dir_read;
   wire [5:0] ram_index;
   integer i;

   assign go = cmd_reg[`CMD_GO_BIT];
   assign dir_read = cmd_reg[`CMD_DIR_BIT];
   // Unit interval times sixteen plus sample
   assign ram_index = {cmd_reg[`CMD_UI_HI:`CMD_UI_LO], cmd_reg[`CMD_SAMP_HI:`CMD_SAMP_LO]};

   ////////////////////////////////////////////////////////////////////////////
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         scale_reg <= `RST_SCALE;
      end else if (wr_scale) begin
         scale_reg <= wdata[`SCALE_HI:0];
      end
   end

   // Access runs the cycle after go is written; go then clears itself
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         cmd_reg <= `RST_CMD;
      end else if (wr_cmd) begin
         cmd_reg <= wdata;
      end else if (go) begin
         cmd_reg[`CMD_GO_BIT] <= 1'b0;
      end
   end

   // Read completion wins over a software write in the same cycle
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         data_reg <= `RST_DATA;
      end else if (go && dir_read) begin
         data_reg <= ram[ram_index];
      end else if (wr_data) begin
         data_reg <= wdata[`DATA_HI:0];
      end
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         for (i = 0; i < 64; i = i + 1) begin
            ram[i] <= 7'h00;
         end
      end else if (go && !dir_read) begin
         ram[ram_index] <= data_reg;
      end
   end

   // Shaper sees the template only in user-programmable mode
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         shaper_sample_reg <= 7'h00;
      end else begin
         shaper_sample_reg <= user_mode ? ram[shaper_index] : 7'h00;
      end
   end

endmodule // template_channel
`default_nettype wire

// ===== verilog/tx_pulse_template_access.v
// AHB-Lite register bank for two channels of transmit pulse template access
//
// Functional notes
// - Six-bit amplitude scale in bits 5..0, reset 100001, scales user pulse.
// - T1 short haul, J1, DS1 0 dB: recommend 110110, two percent per step.
// - DS1 -7.5 dB: recommend 010001, 6.25 percent per step.
// - DS1 -15 dB: recommend 001000, 12.5 percent per step.
// - DS1 -22.5 dB: recommend 000100, 25 percent per step.
// - E1 75 and 120 ohm: recommend 100001, three percent per step.
// - Writing one to go bit 7 starts the indirect template access.
// - Direction bit 6: zero writes the RAM, one reads it.
// - Bits 5..4 pick one of four unit intervals, 00 leftmost.
// - Bits 3..0 pick one of sixteen samples, 0000 leftmost.
// - Indirect write stores the seven-bit data field at the addressed sample.
// - Indirect read returns the addressed sample into the data field.
// - Each channel has its own registers: 06H-08H and 26H-28H.
`timescale 1ns/10ps
`default_nettype none
`include "tx_pulse_consts.vh"

module tx_pulse_template_access (
   input wire clock,
   input wire rst,
   // AHB-Lite slave
   input wire hsel,
   input wire [31:0] haddr,
   input wire [1:0] htrans,
   input wire hwrite,
   input wire [2:0] hsize,
   input wire [31:0] hwdata,
   input wire hready,
   output reg hreadyout,
   output reg hresp,
   output reg [31:0] hrdata,
   // Template selection from the transmit configuration
   input wire [3:0] template_select_ch1,
   input wire [3:0] template_select_ch2,
   // Waveform shaper side
   input wire [5:0] shaper_index_ch1,
   input wire [5:0] shaper_index_ch2,
   output reg [6:0] shaper_sample_ch1,
   output reg [6:0] shaper_sample_ch2,
   output reg [5:0] amplitude_scale_ch1,
   output reg [5:0] amplitude_scale_ch2,
   output reg [5:0] recommended_scale_ch1,
   output reg [5:0] recommended_scale_ch2,
   output reg [11:0] scale_step_ch1,
   output reg [11:0] scale_step_ch2
);

   ////////////////////////////////////////////////////////////////////////////
   // Bus state machine
   localparam [2:0] st_idle = 3'b001;
   localparam [2:0] st_write = 3'b010;
   localparam [2:0] st_read = 3'b100;

   reg [2:0] state_reg;
   reg [2:0] state_next;
   reg [5:0] index_reg;
   reg [5:0] index_next;
   reg [31:0] rdata_next;

   wire addr_phase;
   wire [5:0] addr_index;

   wire [5:0] scale_ch1;
   wire [5:0] scale_ch2;
   wire [7:0] cmd_ch1;
   wire [7:0] cmd_ch2;
   wire [6:0] data_ch1;
   wire [6:0] data_ch2;
   wire [6:0] sample_ch1;
   wire [6:0] sample_ch2;

   reg wr_scale_ch1;
   reg wr_cmd_ch1;
   reg wr_data_ch1;
   reg wr_scale_ch2;
   reg wr_cmd_ch2;
   reg wr_data_ch2;

   wire user_mode_ch1;
   wire user_mode_ch2;

   // Only whole-word transfers are expected; size is not checked
   assign addr_phase = hsel && hready && (htrans == `HTRANS_NONSEQ || htrans == `HTRANS_SEQ);
   assign addr_index = haddr[7:2];

   // Select codes 11xx enable the programmable template
   assign user_mode_ch1 = (template_select_ch1[3:2] == `SEL_USER_HI);
   assign user_mode_ch2 = (template_select_ch2[3:2] == `SEL_USER_HI);

   always @* begin
      state_next = state_reg;
      index_next = index_reg;
      case (state_reg)
         st_idle: begin
            if (addr_phase) begin
               index_next = addr_index;
               state_next = hwrite ? st_write : st_read;
            end
         end
         st_write: begin
            // Write data lands now; a pipelined next address is taken too
            if (addr_phase) begin
               index_next = addr_index;
               state_next = hwrite ? st_write : st_read;
            end else begin
               state_next = st_idle;
            end
         end
         st_read: begin
            // One wait cycle so reads see any write that just landed
            state_next = st_idle;
         end
         default: begin
            state_next = st_idle;
         end
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         state_reg <= st_idle;
         index_reg <= 6'h00;
      end else begin
         state_reg <= state_next;
         index_reg <= index_next;
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Write strobes, one per register per channel
   always @* begin
      wr_scale_ch1 = 1'b0;
      wr_cmd_ch1 = 1'b0;
      wr_data_ch1 = 1'b0;
      wr_scale_ch2 = 1'b0;
      wr_cmd_ch2 = 1'b0;
      wr_data_ch2 = 1'b0;
      if (state_reg == st_write) begin
         case (index_reg)
            `IDX_CH1_SCALE: wr_scale_ch1 = 1'b1;
            `IDX_CH1_CMD: wr_cmd_ch1 = 1'b1;
            `IDX_CH1_DATA: wr_data_ch1 = 1'b1;
            `IDX_CH2_SCALE: wr_scale_ch2 = 1'b1;
            `IDX_CH2_CMD: wr_cmd_ch2 = 1'b1;
            `IDX_CH2_DATA: wr_data_ch2 = 1'b1;
            default: wr_scale_ch1 = 1'b0;
         endcase
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Read mux; reserved bits and unmapped words read as zero
   always @* begin
      rdata_next = 32'h0000_0000;
      case (index_reg)
         `IDX_CH1_SCALE: rdata_next = {26'h0000000, scale_ch1};
         `IDX_CH1_CMD: rdata_next = {24'h000000, cmd_ch1};
         `IDX_CH1_DATA: rdata_next = {25'h0000000, data_ch1};
         `IDX_CH2_SCALE: rdata_next = {26'h0000000, scale_ch2};
         `IDX_CH2_CMD: rdata_next = {24'h000000, cmd_ch2};
         `IDX_CH2_DATA: rdata_next = {25'h0000000, data_ch2};
         default: rdata_next = 32'h0000_0000;
      endcase
   end

   always @(posedge clock or posedge rst) begin
      if (rst) begin
         hrdata <= 32'h0000_0000;
         hreadyout <= 1'b1;
         hresp <= 1'b0;
      end else begin
         hresp <= 1'b0;
         if (state_reg == st_read) begin
            hrdata <= rdata_next;
            hreadyout <= 1'b1;
         end else if (state_next == st_read) begin
            hreadyout <= 1'b0;
         end else begin
            hreadyout <= 1'b1;
         end
      end
   end

   ////////////////////////////////////////////////////////////////////////////
   // Two independent channel copies
   template_channel u_channel1 (
      .clock(clock),
      .rst(rst),
      .wr_scale(wr_scale_ch1),
      .wr_cmd(wr_cmd_ch1),
      .wr_data(wr_data_ch1),
      .wdata(hwdata[7:0]),
      .user_mode(user_mode_ch1),
      .shaper_index(shaper_index_ch1),
      .scale_reg(scale_ch1),
      .cmd_reg(cmd_ch1),
      .data_reg(data_ch1),
      .shaper_sample_reg(sample_ch1)
   );

   template_channel u_channel2 (
      .clock(clock),
      .rst(rst),
      .wr_scale(wr_scale_ch2),
      .wr_cmd(wr_cmd_ch2),
      .wr_data(wr_data_ch2),
      .wdata(hwdata[7:0]),
      .user_mode(user_mode_ch2),
      .shaper_index(shaper_index_ch2),
      .scale_reg(scale_ch2),
      .cmd_reg(cmd_ch2),
      .data_reg(data_ch2),
      .shaper_sample_reg(sample_ch2)
   );

   ////////////////////////////////////////////////////////////////////////////
   // Recommended scale and step size per selected line type.
   // Advisory only: the active scale is always the software value, so a
   // user template can be tuned away from the suggestion.
   function [5:0] rec_scale;
      input [3:0] sel;
      begin
         case (sel)
            `SEL_E1_INT: rec_scale = `SCALE_E1;
            `SEL_E1_EXT: rec_scale = `SCALE_E1;
            `SEL_DS1_M75: rec_scale = `SCALE_DS1_M75;
            `SEL_DS1_M150: rec_scale = `SCALE_DS1_M150;
            `SEL_DS1_M225: rec_scale = `SCALE_DS1_M225;
            default: rec_scale = `SCALE_T1_SHORT;
         endcase
      end
   endfunction

   function [11:0] step_size;
      input [3:0] sel;
      begin
         case (sel)
            `SEL_E1_INT: step_size = `STEP_E1;
            `SEL_E1_EXT: step_size = `STEP_E1;
            `SEL_DS1_M75: step_size = `STEP_DS1_M75;
            `SEL_DS1_M150: step_size = `STEP_DS1_M150;
            `SEL_DS1_M225: step_size = `STEP_DS1_M225;
            default: step_size = `STEP_T1_SHORT;
         endcase
      end
   endfunction

   ////////////////////////////////////////////////////////////////////////////
   // Registered outputs toward the shaper
   always @(posedge clock or posedge rst) begin
      if (rst) begin
         shaper_sample_ch1 <= 7'h00;
         shaper_sample_ch2 <= 7'h00;
         amplitude_scale_ch1 <= `RST_SCALE;
         amplitude_scale_ch2 <= `RST_SCALE;
         recommended_scale_ch1 <= `SCALE_E1;
         recommended_scale_ch2 <= `SCALE_E1;
         scale_step_ch1 <= `STEP_E1;
         scale_step_ch2 <= `STEP_E1;
      end else begin
         shaper_sample_ch1 <= sample_ch1;
         shaper_sample_ch2 <= sample_ch2;
         amplitude_scale_ch1 <= scale_ch1;
         amplitude_scale_ch2 <= scale_ch2;
         recommended_scale_ch1 <= rec_scale(template_select_ch1);
         recommended_scale_ch2 <= rec_scale(template_select_ch2);
         scale_step_ch1 <= step_size(template_select_ch1);
         scale_step_ch2 <= step_size(template_select_ch2);
      end
   end

endmodule // tx_pulse_template_access
`default_nettype wire

// ===== verification/tpta_props.sv
// Port checks for the transmit pulse template access register bank
`timescale 1ns/10ps
`default_nettype none
module tpta_props (
   input wire logic clock,
   input wire logic rst,
   input wire logic hsel,
   input wire logic [31:0] haddr,
   input wire logic [1:0] htrans,
   input wire logic hwrite,
   input wire logic [31:0] hwdata,
   input wire logic hready,
   input wire logic hreadyout,
   input wire logic hresp,
   input wire logic [31:0] hrdata,
   input wire logic [3:0] template_select_ch1,
   input wire logic [6:0] shaper_sample_ch1,
   input wire logic [5:0] amplitude_scale_ch1,
   input wire logic [5:0] amplitude_scale_ch2,
   input wire logic [5:0] recommended_scale_ch1,
   input wire logic [11:0] scale_step_ch1
);
   wire logic take = hsel && hready && htrans[1];
   wire logic take_scale1 = take && hwrite && haddr[7:2] == 6'h06;
   wire logic [5:0] scale_data = hwdata[5:0];
   function automatic logic [17:0] rec(input logic [3:0] s);
      case (s)
         4'h0, 4'h1: rec = {6'h21, 12'd300};
         4'h9: rec = {6'h11, 12'd625};
         4'ha: rec = {6'h08, 12'd1250};
         4'hb: rec = {6'h04, 12'd2500};
         default: rec = {6'h36, 12'd200};
      endcase
   endfunction
   default clocking @(posedge clock); endclocking
   default disable iff (rst);
   ////////////////////////////////////////////////////////////////////////////////
   AST_READ_WAIT: assert property (take && !hwrite |=> !hreadyout ##1 hreadyout)
      else $error("read answer not after one wait cycle");
   AST_WRITE_NOWAIT: assert property (take && hwrite |=> hreadyout)
      else $error("write data phase stalled");
   AST_HRESP_OKAY: assert property (hresp == 1'b0)
      else $error("response not okay");
   AST_SCALE1: assert property (take && hwrite && haddr[7:2] == 6'h06
      |=> ##2 amplitude_scale_ch1 == $past(scale_data, 2)) else $error("ch1 scale wrong");
   AST_SCALE2: assert property (take && hwrite && haddr[7:2] == 6'h26
      |=> ##2 amplitude_scale_ch2 == $past(scale_data, 2)) else $error("ch2 scale wrong");
   AST_SCALE_HOLD: assert property (!$stable(amplitude_scale_ch1)
      |-> $past(take_scale1, 3)) else $error("scale moved alone");
   AST_RECOMMEND: assert property ($stable(template_select_ch1)
      && template_select_ch1[3:2] != 2'h3
      |=> {recommended_scale_ch1, scale_step_ch1} == rec($past(template_select_ch1)))
      else $error("advisory scale wrong");
   AST_SHAPER_GATE: assert property ((template_select_ch1[3:2] != 2'h3)[*2]
      |=> shaper_sample_ch1 == 7'h0) else $error("shaper sample outside user mode");
   AST_HRDATA_HOLD: assert property (!$stable(hrdata) |-> !$past(hreadyout))
      else $error("read data changed without a read");
endmodule // tpta_props
bind tx_pulse_template_access tpta_props props (.clock, .rst, .hsel, .haddr, .htrans,
   .hwrite, .hwdata, .hready, .hreadyout, .hresp, .hrdata, .template_select_ch1,
   .shaper_sample_ch1, .amplitude_scale_ch1, .amplitude_scale_ch2,
   .recommended_scale_ch1, .scale_step_ch1);
`default_nettype wire

// ===== verification/tx_pulse_template_access_tb.sv
// Self-checking bench for the transmit pulse template access register bank
`timescale 1ns/10ps
`default_nettype none
`include "tx_pulse_consts.vh"
module tx_pulse_template_access_tb;
   logic clock, rst, hsel, hwrite, hreadyout, hresp;
   logic [31:0] haddr, hwdata, hrdata, q;
   logic [1:0] htrans;
   logic [2:0] hsize;
   logic [3:0] sel1, sel2;
   logic [5:0] si1, si2, as1, as2, rs1, rs2, a;
   logic [6:0] ss1, ss2;
   logic [11:0] st1, st2;
   logic [15:0] seed;
   logic [5:0] m_scale [2];
   logic [6:0] m_data [2];
   logic [6:0] m_ram [2][64];
   int fail_count, checked;
   tx_pulse_template_access dut (.clock(clock), .rst(rst), .hsel(hsel), .haddr(haddr),
      .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
      .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .template_select_ch1(sel1),
      .template_select_ch2(sel2), .shaper_index_ch1(si1), .shaper_index_ch2(si2),
      .shaper_sample_ch1(ss1), .shaper_sample_ch2(ss2), .amplitude_scale_ch1(as1),
      .amplitude_scale_ch2(as2), .recommended_scale_ch1(rs1), .recommended_scale_ch2(rs2),
      .scale_step_ch1(st1), .scale_step_ch2(st2));
   ////////////////////////////////////////////////////////////////////////////////
   function automatic logic [15:0] lfsr(input logic [15:0] s);
      return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
   endfunction
   function automatic logic [5:0] base(input int c);
      return c ? `IDX_CH2_SCALE : `IDX_CH1_SCALE;
   endfunction
   function automatic logic [17:0] rec(input int s);
      if (s < 2) return {6'h21, 12'd300};
      if (s == 9) return {6'h11, 12'd625};
      if (s == 10) return {6'h08, 12'd1250};
      if (s == 11) return {6'h04, 12'd2500};
      return {6'h36, 12'd200};
   endfunction
   task automatic complete_run;
      $display("checked %0d fail_count %0d", checked, fail_count);
      if (fail_count == 0 && checked > 0) $display("Testbench passed");
      else $display("Testbench failed");
      $finish;
   endtask
   task automatic check_word(input string nm, input logic [31:0] e, input logic [31:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   task automatic check_pin(input string nm, input logic [17:0] e, input logic [17:0] g);
      checked++;
      if (g !== e) begin
         fail_count++;
         $display("ERROR %s expected %h seen %h", nm, e, g);
      end
   endtask
   // Bounded wait, so a slave that never answers still ends the run
   task automatic wait_ready;
      int n;
      n = 0;
      do begin
         @(posedge clock);
         n++;
      end while (hreadyout !== 1'b1 && n < 20);
      if (n >= 20) begin
         fail_count++;
         $display("ERROR hreadyout expected 1 seen %b", hreadyout);
         complete_run();
      end
   endtask
   task automatic bus(input logic w, input logic [5:0] i, input logic [31:0] d);
      hwrite <= w;
      haddr <= {24'h0, i, 2'b00};
      htrans <= `HTRANS_NONSEQ;
      wait_ready();
      htrans <= 2'h0;
      hwdata <= d;
      wait_ready();
      q = hrdata;
   endtask
   task automatic rd(input logic [5:0] i, input logic [31:0] e, input string nm);
      bus(1'b0, i, 32'h0);
      check_word(nm, e, q);
      check_pin("hresp", 18'h0, {17'h0, hresp});
   endtask
   ////////////////////////////////////////////////////////////////////////////////
   initial begin
      clock = 1'b0;
      forever #10 clock = ~clock;
   end
   initial begin
      {rst, hsel, hwrite, hsize} = 6'h32;
      {haddr, hwdata, htrans, sel1, sel2, si1, si2} = '0;
      {fail_count, checked, seed} = {32'd0, 32'd0, 16'd17};
      m_scale = '{6'h21, 6'h21};
      m_data = '{7'h0, 7'h0};
      m_ram = '{default: 7'h0};
      repeat (6) @(posedge clock);
      rst <= 1'b0;
      for (int c = 0; c < 2; c++) begin
         rd(base(c), 32'h21, "scale");
         rd(base(c) + 6'd1, 32'h0, "command");
         rd(base(c) + 6'd2, 32'h0, "data");
      end
      rd(6'h09, 32'h0, "unmapped");
      check_pin("scale out", 18'h21, {12'h0, as1});
      check_pin("advisory", rec(0), {rs1, st1});
      check_pin("shaper", 18'h0, {11'h0, ss1});
      $display("test reset finished");
      // Upper bits written as ones must not stick
      for (int c = 0; c < 2; c++) begin
         for (int k = 0; k < 3; k++) begin
            seed = lfsr(seed);
            bus(1'b1, base(c), k == 0 ? 32'hffffffff : {16'h0, seed});
            m_scale[c] = k == 0 ? 6'h3f : seed[5:0];
            rd(base(c), {26'h0, m_scale[c]}, "scale");
         end
      end
      rd(base(0), {26'h0, m_scale[0]}, "scale");
      check_pin("scale out", {12'h0, m_scale[0]}, {12'h0, as1});
      check_pin("scale out", {12'h0, m_scale[1]}, {12'h0, as2});
      bus(1'b1, 6'h09, 32'hff);
      rd(6'h09, 32'h0, "unmapped");
      $display("test scale finished");
      for (int s = 0; s < 12; s++) begin
         sel1 <= s[3:0];
         sel2 <= 4'(11 - s);
         repeat (2) @(posedge clock);
         check_pin("advisory", rec(s), {rs1, st1});
         check_pin("advisory", rec(11 - s), {rs2, st2});
      end
      $display("test advisory finished");
      for (int n = 0; n < 16; n++) begin
         seed = lfsr(seed);
         a = n < 2 ? 6'h0 : n < 4 ? 6'h3f : seed[5:0];
         bus(1'b1, base(n % 2) + 6'd2, {24'h0, seed[15:8]});
         m_ram[n % 2][a] = seed[14:8];
         bus(1'b1, base(n % 2) + 6'd1, {24'h0, 2'b10, a});
         rd(base(n % 2) + 6'd1, {26'h0, a}, "command");
      end
      // Every entry is read back, so a write landing at the wrong index shows
      for (int c = 0; c < 2; c++) begin
         for (int i = 0; i < 64; i++) begin
            bus(1'b1, base(c) + 6'd1, {24'h0, 2'b11, 6'(i)});
            rd(base(c) + 6'd1, {24'h0, 2'b01, 6'(i)}, "command");
            rd(base(c) + 6'd2, {25'h0, m_ram[c][i]}, "data");
         end
      end
      $display("test template ram finished");
      sel1 <= 4'hc;
      sel2 <= 4'hf;
      for (int n = 0; n < 8; n++) begin
         seed = lfsr(seed);
         si1 <= seed[5:0];
         si2 <= ~seed[5:0];
         repeat (3) @(posedge clock);
         check_pin("shaper", {11'h0, m_ram[0][seed[5:0]]}, {11'h0, ss1});
         check_pin("shaper", {11'h0, m_ram[1][~seed[5:0]]}, {11'h0, ss2});
      end
      sel1 <= 4'h9;
      repeat (3) @(posedge clock);
      check_pin("shaper", 18'h0, {11'h0, ss1});
      $display("test shaper finished");
      complete_run();
   end
endmodule // tx_pulse_template_access_tb
`default_nettype wire
